// File: arp_pkg.sv
`default_nettype none
package arp_pkg;

    // datapath geometry
    localparam int BYTE_W = 8;
    localparam int WORD_W = 32;
    localparam int STATE_W = 128;
    localparam int NCOL = 4;
    localparam int NROW = 4;

    // low byte of the field polynomial once the x^8 term is folded back
    localparam logic [7:0] GF_REDUCE = 8'h1B;
    localparam logic [7:0] GF_ZERO = 8'h00;

    // column mixing coefficients
    localparam logic [7:0] MIX_C2 = 8'h02;
    localparam logic [7:0] MIX_C3 = 8'h03;
    localparam logic [7:0] IMX_CE = 8'h0E;
    localparam logic [7:0] IMX_CB = 8'h0B;
    localparam logic [7:0] IMX_CD = 8'h0D;
    localparam logic [7:0] IMX_C9 = 8'h09;

    // operations issued by the execution datapath
    typedef enum logic [2:0] {
        OP_ENC_ROUND,
        OP_ENC_FINAL,
        OP_DEC_ROUND,
        OP_DEC_FINAL,
        OP_INV_MIX,
        OP_KEY_ASSIST
    } arp_op_t;

    // one request: operation, state, round key, round constant
    typedef struct packed {
        arp_op_t op;
        logic [STATE_W-1:0] state;
        logic [STATE_W-1:0] key;
        logic [BYTE_W-1:0] rcon;
    } arp_req_t;

    // forward substitution, indexed by the byte itself (hi nibble = row)
    localparam logic [7:0] SBOX [256] = '{
    8'h63,8'h7C,8'h77,8'h7B,8'hF2,8'h6B,8'h6F,8'hC5,8'h30,8'h01,8'h67,8'h2B,
    8'hFE,8'hD7,8'hAB,8'h76,8'hCA,8'h82,8'hC9,8'h7D,8'hFA,8'h59,8'h47,8'hF0,
    8'hAD,8'hD4,8'hA2,8'hAF,8'h9C,8'hA4,8'h72,8'hC0,8'hB7,8'hFD,8'h93,8'h26,
    8'h36,8'h3F,8'hF7,8'hCC,8'h34,8'hA5,8'hE5,8'hF1,8'h71,8'hD8,8'h31,8'h15,
    8'h04,8'hC7,8'h23,8'hC3,8'h18,8'h96,8'h05,8'h9A,8'h07,8'h12,8'h80,8'hE2,
    8'hEB,8'h27,8'hB2,8'h75,8'h09,8'h83,8'h2C,8'h1A,8'h1B,8'h6E,8'h5A,8'hA0,
    8'h52,8'h3B,8'hD6,8'hB3,8'h29,8'hE3,8'h2F,8'h84,8'h53,8'hD1,8'h00,8'hED,
    8'h20,8'hFC,8'hB1,8'h5B,8'h6A,8'hCB,8'hBE,8'h39,8'h4A,8'h4C,8'h58,8'hCF,
    8'hD0,8'hEF,8'hAA,8'hFB,8'h43,8'h4D,8'h33,8'h85,8'h45,8'hF9,8'h02,8'h7F,
    8'h50,8'h3C,8'h9F,8'hA8,8'h51,8'hA3,8'h40,8'h8F,8'h92,8'h9D,8'h38,8'hF5,
    8'hBC,8'hB6,8'hDA,8'h21,8'h10,8'hFF,8'hF3,8'hD2,8'hCD,8'h0C,8'h13,8'hEC,
    8'h5F,8'h97,8'h44,8'h17,8'hC4,8'hA7,8'h7E,8'h3D,8'h64,8'h5D,8'h19,8'h73,
    8'h60,8'h81,8'h4F,8'hDC,8'h22,8'h2A,8'h90,8'h88,8'h46,8'hEE,8'hB8,8'h14,
    8'hDE,8'h5E,8'h0B,8'hDB,8'hE0,8'h32,8'h3A,8'h0A,8'h49,8'h06,8'h24,8'h5C,
    8'hC2,8'hD3,8'hAC,8'h62,8'h91,8'h95,8'hE4,8'h79,8'hE7,8'hC8,8'h37,8'h6D,
    8'h8D,8'hD5,8'h4E,8'hA9,8'h6C,8'h56,8'hF4,8'hEA,8'h65,8'h7A,8'hAE,8'h08,
    8'hBA,8'h78,8'h25,8'h2E,8'h1C,8'hA6,8'hB4,8'hC6,8'hE8,8'hDD,8'h74,8'h1F,
    8'h4B,8'hBD,8'h8B,8'h8A,8'h70,8'h3E,8'hB5,8'h66,8'h48,8'h03,8'hF6,8'h0E,
    8'h61,8'h35,8'h57,8'hB9,8'h86,8'hC1,8'h1D,8'h9E,8'hE1,8'hF8,8'h98,8'h11,
    8'h69,8'hD9,8'h8E,8'h94,8'h9B,8'h1E,8'h87,8'hE9,8'hCE,8'h55,8'h28,8'hDF,
    8'h8C,8'hA1,8'h89,8'h0D,8'hBF,8'hE6,8'h42,8'h68,8'h41,8'h99,8'h2D,8'h0F,
    8'hB0,8'h54,8'hBB,8'h16};

    // inverse substitution
    localparam logic [7:0] ISBOX [256] = '{
    8'h52,8'h09,8'h6A,8'hD5,8'h30,8'h36,8'hA5,8'h38,8'hBF,8'h40,8'hA3,8'h9E,
    8'h81,8'hF3,8'hD7,8'hFB,8'h7C,8'hE3,8'h39,8'h82,8'h9B,8'h2F,8'hFF,8'h87,
    8'h34,8'h8E,8'h43,8'h44,8'hC4,8'hDE,8'hE9,8'hCB,8'h54,8'h7B,8'h94,8'h32,
    8'hA6,8'hC2,8'h23,8'h3D,8'hEE,8'h4C,8'h95,8'h0B,8'h42,8'hFA,8'hC3,8'h4E,
    8'h08,8'h2E,8'hA1,8'h66,8'h28,8'hD9,8'h24,8'hB2,8'h76,8'h5B,8'hA2,8'h49,
    8'h6D,8'h8B,8'hD1,8'h25,8'h72,8'hF8,8'hF6,8'h64,8'h86,8'h68,8'h98,8'h16,
    8'hD4,8'hA4,8'h5C,8'hCC,8'h5D,8'h65,8'hB6,8'h92,8'h6C,8'h70,8'h48,8'h50,
    8'hFD,8'hED,8'hB9,8'hDA,8'h5E,8'h15,8'h46,8'h57,8'hA7,8'h8D,8'h9D,8'h84,
    8'h90,8'hD8,8'hAB,8'h00,8'h8C,8'hBC,8'hD3,8'h0A,8'hF7,8'hE4,8'h58,8'h05,
    8'hB8,8'hB3,8'h45,8'h06,8'hD0,8'h2C,8'h1E,8'h8F,8'hCA,8'h3F,8'h0F,8'h02,
    8'hC1,8'hAF,8'hBD,8'h03,8'h01,8'h13,8'h8A,8'h6B,8'h3A,8'h91,8'h11,8'h41,
    8'h4F,8'h67,8'hDC,8'hEA,8'h97,8'hF2,8'hCF,8'hCE,8'hF0,8'hB4,8'hE6,8'h73,
    8'h96,8'hAC,8'h74,8'h22,8'hE7,8'hAD,8'h35,8'h85,8'hE2,8'hF9,8'h37,8'hE8,
    8'h1C,8'h75,8'hDF,8'h6E,8'h47,8'hF1,8'h1A,8'h71,8'h1D,8'h29,8'hC5,8'h89,
    8'h6F,8'hB7,8'h62,8'h0E,8'hAA,8'h18,8'hBE,8'h1B,8'hFC,8'h56,8'h3E,8'h4B,
    8'hC6,8'hD2,8'h79,8'h20,8'h9A,8'hDB,8'hC0,8'hFE,8'h78,8'hCD,8'h5A,8'hF4,
    8'h1F,8'hDD,8'hA8,8'h33,8'h88,8'h07,8'hC7,8'h31,8'hB1,8'h12,8'h10,8'h59,
    8'h27,8'h80,8'hEC,8'h5F,8'h60,8'h51,8'h7F,8'hA9,8'h19,8'hB5,8'h4A,8'h0D,
    8'h2D,8'hE5,8'h7A,8'h9F,8'h93,8'hC9,8'h9C,8'hEF,8'hA0,8'hE0,8'h3B,8'h4D,
    8'hAE,8'h2A,8'hF5,8'hB0,8'hC8,8'hEB,8'hBB,8'h3C,8'h83,8'h53,8'h99,8'h61,
    8'h17,8'h2B,8'h04,8'h7E,8'hBA,8'h77,8'hD6,8'h26,8'hE1,8'h69,8'h14,8'h63,
    8'h55,8'h21,8'h0C,8'h7D};

endpackage
`default_nettype wire

// File: arp_core.sv
`timescale 1ns/1ns
`default_nettype none

module arp_core
    import arp_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // request from the execution datapath
    input wire logic req_valid,
    input wire arp_req_t req,
    // registered result
    output logic rsp_valid,
    output logic [STATE_W-1:0] rsp_data
);

    // field multiply: shift-and-add with reduction folded into each step
    function automatic logic [7:0] gf_mul(input logic [7:0] a,
                                          input logic [7:0] b);
        logic [7:0] p;
        logic [7:0] t;
        p = GF_ZERO;
        t = a;
        for (int k = 0; k < BYTE_W; k++) begin
            if (b[k]) p = p ^ t;
            t = {t[BYTE_W-2:0], 1'b0} ^
                (t[BYTE_W-1] ? GF_REDUCE : GF_ZERO);
        end
        return p;
    endfunction

    // byte (i,j) of the state sits at byte index 4j+i
    function automatic logic [7:0] st(input logic [STATE_W-1:0] s,
                                      input int i, input int j);
        return s[(NROW*j + i)*BYTE_W +: BYTE_W];
    endfunction

    function automatic logic [STATE_W-1:0] mix(input logic [STATE_W-1:0] s);
        logic [STATE_W-1:0] o;
        o = '0;
        for (int j = 0; j < NCOL; j++) begin
            for (int i = 0; i < NROW; i++) begin
                o[(NROW*j + i)*BYTE_W +: BYTE_W] =
                    gf_mul(MIX_C2, st(s, i, j)) ^
                    gf_mul(MIX_C3, st(s, (i + 1) % NROW, j)) ^
                    st(s, (i + 2) % NROW, j) ^
                    st(s, (i + 3) % NROW, j);
            end
        end
        return o;
    endfunction

    function automatic logic [STATE_W-1:0] inv_mix(
        input logic [STATE_W-1:0] s);
        logic [STATE_W-1:0] o;
        o = '0;
        for (int j = 0; j < NCOL; j++) begin
            for (int i = 0; i < NROW; i++) begin
                o[(NROW*j + i)*BYTE_W +: BYTE_W] =
                    gf_mul(IMX_CE, st(s, i, j)) ^
                    gf_mul(IMX_CB, st(s, (i + 1) % NROW, j)) ^
                    gf_mul(IMX_CD, st(s, (i + 2) % NROW, j)) ^
                    gf_mul(IMX_C9, st(s, (i + 3) % NROW, j));
            end
        end
        return o;
    endfunction

    // row i of column j takes the byte from column j+i (left rotate)
    function automatic logic [STATE_W-1:0] shift(input logic [STATE_W-1:0] s);
        logic [STATE_W-1:0] o;
        o = '0;
        for (int j = 0; j < NCOL; j++) begin
            for (int i = 0; i < NROW; i++) begin
                o[(NROW*j + i)*BYTE_W +: BYTE_W] =
                    st(s, i, (j + i) % NCOL);
            end
        end
        return o;
    endfunction

    // right rotate: row i of column j comes from column j-i
    function automatic logic [STATE_W-1:0] inv_shift(
        input logic [STATE_W-1:0] s);
        logic [STATE_W-1:0] o;
        o = '0;
        for (int j = 0; j < NCOL; j++) begin
            for (int i = 0; i < NROW; i++) begin
                o[(NROW*j + i)*BYTE_W +: BYTE_W] =
                    st(s, i, (j + NCOL - i) % NCOL);
            end
        end
        return o;
    endfunction

    // byte value doubles as {row nibble, column nibble} of the table
    function automatic logic [STATE_W-1:0] sub(input logic [STATE_W-1:0] s,
                                               input logic inv);
        logic [STATE_W-1:0] o;
        o = '0;
        for (int b = 0; b < STATE_W / BYTE_W; b++) begin
            o[b*BYTE_W +: BYTE_W] = inv ? ISBOX[s[b*BYTE_W +: BYTE_W]]
                : SBOX[s[b*BYTE_W +: BYTE_W]];
        end
        return o;
    endfunction

    function automatic logic [WORD_W-1:0] sub_word(input logic [WORD_W-1:0] w);
        logic [WORD_W-1:0] o;
        o = '0;
        for (int b = 0; b < WORD_W / BYTE_W; b++) begin
            o[b*BYTE_W +: BYTE_W] = SBOX[w[b*BYTE_W +: BYTE_W]];
        end
        return o;
    endfunction

    function automatic logic [WORD_W-1:0] rot_word(input logic [WORD_W-1:0] w);
        return {w[BYTE_W-1:0], w[WORD_W-1:BYTE_W]};
    endfunction

    // reset release through two flops; assertion is immediate
    logic [1:0] rst_sync_ff;
    logic rst_int_n;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) rst_sync_ff <= 2'h0;
        else rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
    assign rst_int_n = rst_sync_ff[1];

    // operation select; everything is combinational up to the output stage
    logic [WORD_W-1:0] rcon_w;
    logic [WORD_W-1:0] sw1;
    logic [WORD_W-1:0] sw3;
    logic [STATE_W-1:0] op_result;
    logic nxt_rsp_valid;
    logic [STATE_W-1:0] nxt_rsp_data;
    logic rsp_valid_ff;
    logic [STATE_W-1:0] rsp_data_ff;

    assign rcon_w = {{(WORD_W-BYTE_W){1'b0}}, req.rcon};
    assign sw1 = sub_word(req.state[WORD_W +: WORD_W]);
    assign sw3 = sub_word(req.state[3*WORD_W +: WORD_W]);

    always_comb begin
        unique case (req.op)
            OP_ENC_ROUND: op_result =
                mix(sub(shift(req.state), 1'b0)) ^ req.key;
            OP_ENC_FINAL: op_result = sub(shift(req.state), 1'b0) ^ req.key;
            OP_DEC_ROUND: op_result =
                inv_mix(sub(inv_shift(req.state), 1'b1)) ^ req.key;
            OP_DEC_FINAL: op_result =
                sub(inv_shift(req.state), 1'b1) ^ req.key;
            OP_INV_MIX: op_result = inv_mix(req.state);
            OP_KEY_ASSIST: op_result = {rot_word(sw3) ^ rcon_w, sw3,
                                        rot_word(sw1) ^ rcon_w, sw1};
            default: op_result = '0; // an illegal op code yields zero
        endcase
    end

    // output stage: data held until the next accepted request
    always_comb begin
        nxt_rsp_valid = req_valid;
        nxt_rsp_data = req_valid ? op_result : rsp_data_ff;
    end

    always_ff @(posedge core_clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            rsp_valid_ff <= 1'b0;
            rsp_data_ff <= '0;
        end else begin
            rsp_valid_ff <= nxt_rsp_valid;
            rsp_data_ff <= nxt_rsp_data;
        end
    end

    assign rsp_valid = rsp_valid_ff;
    assign rsp_data = rsp_data_ff;

    // checks tie substitution, column mix and row shift to their inverses and word rotation to an independent form
    chk_rsp_latency: assert property (
        @(posedge core_clk) disable iff (!rst_int_n)
        req_valid |=> rsp_valid && rsp_data == $past(op_result))
        else $error("result not registered one cycle after request");

    chk_rsp_hold: assert property (
        @(posedge core_clk) disable iff (!rst_int_n)
        !req_valid |=> !rsp_valid && $stable(rsp_data))
        else $error("result changed without a request");

    chk_sbox_roundtrip: assert property (
        @(posedge core_clk) disable iff (!rst_int_n)
        sub(sub(req.state, 1'b0), 1'b1) == req.state)
        else $error("inverse substitution does not undo forward");

    chk_mix_inverse: assert property (
        @(posedge core_clk) disable iff (!rst_int_n)
        inv_mix(mix(req.state)) == req.state)
        else $error("inverse column mix does not undo column mix");

    chk_shift_inverse: assert property (
        @(posedge core_clk) disable iff (!rst_int_n)
        inv_shift(shift(req.state)) == req.state)
        else $error("inverse row shift does not undo row shift");

    chk_shift_row1: assert property (
        @(posedge core_clk) disable iff (!rst_int_n)
        st(shift(req.state), 1, 0) == st(req.state, 1, 1) &&
        st(shift(req.state), 0, 3) == st(req.state, 0, 3))
        else $error("row shift moved bytes wrongly");

    chk_gf_linear: assert property (
        @(posedge core_clk) disable iff (!rst_int_n)
        gf_mul(MIX_C3, req.rcon) == (gf_mul(MIX_C2, req.rcon) ^ req.rcon) &&
        gf_mul(req.rcon, req.state[BYTE_W-1:0]) ==
        gf_mul(req.state[BYTE_W-1:0], req.rcon))
        else $error("field multiply not linear or not commutative");

    chk_rot_word: assert property (
        @(posedge core_clk) disable iff (!rst_int_n)
        rot_word(req.key[WORD_W-1:0]) ==
        {req.key[BYTE_W-1:0], req.key[WORD_W-1:BYTE_W]} &&
        rot_word(rot_word(rot_word(rot_word(req.key[WORD_W-1:0])))) ==
        req.key[WORD_W-1:0])
        else $error("word rotation wrong");

    chk_key_assist: assert property (
        @(posedge core_clk) disable iff (!rst_int_n)
        req_valid && req.op == OP_KEY_ASSIST |=>
        rsp_data[WORD_W +: WORD_W] ==
        (rot_word(rsp_data[0 +: WORD_W]) ^ {{(WORD_W-BYTE_W){1'b0}},
                                            $past(req.rcon)}))
        else $error("key assist words inconsistent");

    // main scenarios
    cov_enc_round: cover property (
        @(posedge core_clk) disable iff (!rst_int_n)
        req_valid && req.op == OP_ENC_ROUND);
    cov_dec_final: cover property (
        @(posedge core_clk) disable iff (!rst_int_n)
        req_valid && req.op == OP_DEC_FINAL);
    cov_back_to_back: cover property (
        @(posedge core_clk) disable iff (!rst_int_n)
        req_valid ##1 req_valid && req.op == OP_KEY_ASSIST);

endmodule

`default_nettype wire

// File: arp_exec_model.sv
`timescale 1ns/1ns
`default_nettype none
// execution-side issuer: one request per call
module arp_exec_model
    import arp_pkg::*;
(
    // clock
    input wire logic core_clk,
    // request toward the primitives
    output var logic req_valid,
    output var arp_req_t req
);
    initial begin
        req_valid = 1'b0;
        req = '0;
    end
    // launched just after an edge, held for the whole cycle
    task automatic send(input arp_req_t r);
        @(posedge core_clk);
        req_valid <= 1'b1;
        req <= r;
    endtask
    // idle bus must not look like the last request, so invert it
    task automatic idle();
        @(posedge core_clk);
        req_valid <= 1'b0;
        req <= arp_req_t'(~req);
    endtask
endmodule
`default_nettype wire

// File: tb_arp_core.sv
`timescale 1ns/1ns
`default_nettype none
module tb_arp_core
    import arp_pkg::*;
();
    logic core_clk;
    logic rst_n;
    logic req_valid;
    arp_req_t req;
    logic rsp_valid;
    logic [STATE_W-1:0] rsp_data;
    logic [STATE_W-1:0] exp_q[$];
    logic mon_on = 1'b0;
    int failures = 0;
    int comparisons = 0;
    int cycles = 0;

    arp_exec_model i_exec (.core_clk(core_clk), .req_valid(req_valid),
        .req(req));
    arp_core i_dut (.core_clk(core_clk), .rst_n(rst_n),
        .req_valid(req_valid), .req(req), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data));

    // reference field multiply, shift-and-reduce
    function automatic logic [7:0] gm(logic [7:0] a, logic [7:0] b);
        logic [7:0] p;
        p = 8'h00;
        for (int k = 0; k < 8; k++) begin
            if (b[k]) p = p ^ a;
            a = {a[6:0], 1'b0} ^ (a[7] ? 8'h1B : 8'h00);
        end
        return p;
    endfunction

    // k: 0 shift, 1 unshift, 2 sub, 3 unsub, 4 mix, 5 unmix
    function automatic logic [127:0] xf(logic [127:0] s, int k);
        logic [127:0] o;
        logic [7:0] c [4];
        logic [7:0] r;
        for (int j = 0; j < 4; j++) begin
            for (int i = 0; i < 4; i++) c[i] = s[32*j+8*i+:8];
            for (int i = 0; i < 4; i++) begin
                case (k)
                    0: r = s[32*((j+i)%4)+8*i+:8];
                    1: r = s[32*((j+4-i)%4)+8*i+:8];
                    2: r = SBOX[c[i]];
                    3: r = ISBOX[c[i]];
                    4: r = gm(8'h02, c[i]) ^ gm(8'h03, c[(i+1)%4])
                        ^ c[(i+2)%4] ^ c[(i+3)%4];
                    default: r = gm(8'h0E, c[i]) ^ gm(8'h0B, c[(i+1)%4])
                        ^ gm(8'h0D, c[(i+2)%4]) ^ gm(8'h09, c[(i+3)%4]);
                endcase
                o[32*j+8*i+:8] = r;
            end
        end
        return o;
    endfunction

    function automatic logic [127:0] ref_out(arp_req_t q);
        logic [127:0] s;
        logic [31:0] w1;
        logic [31:0] w3;
        logic [31:0] rc;
        s = xf(q.state, 2);
        w1 = s[63:32];
        w3 = s[127:96];
        rc = {24'h000000, q.rcon};
        case (q.op)
            OP_ENC_ROUND: return xf(xf(xf(q.state, 0), 2), 4) ^ q.key;
            OP_ENC_FINAL: return xf(xf(q.state, 0), 2) ^ q.key;
            OP_DEC_ROUND: return xf(xf(xf(q.state, 1), 3), 5) ^ q.key;
            OP_DEC_FINAL: return xf(xf(q.state, 1), 3) ^ q.key;
            OP_INV_MIX: return xf(q.state, 5);
            OP_KEY_ASSIST: return {{w3[7:0], w3[31:8]} ^ rc, w3,
                {w1[7:0], w1[31:8]} ^ rc, w1};
            default: return '0;
        endcase
    endfunction

    task automatic check(string nm, logic [127:0] got, logic [127:0] ex);
        comparisons++;
        if (got !== ex) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, ex, got);
        end
    endtask

    // one request, answer looked at in its only valid cycle
    task automatic go(arp_req_t r, logic [127:0] ex);
        i_exec.send(r);
        i_exec.idle();
        @(negedge core_clk);
        check("rsp_data", rsp_data, ex);
    endtask

    task automatic close_out();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // every taken request answered exactly one cycle later
    always @(posedge core_clk) begin
        cycles++;
        if (mon_on && req_valid) exp_q.push_back(ref_out(req));
        if (cycles == 3000) begin
            failures++;
            close_out();
        end
    end
    always @(negedge core_clk) begin
        if (!mon_on) exp_q.delete();
        else if (exp_q.size() != 0) begin
            check("rsp_valid", 128'(rsp_valid), 128'h1);
            check("rsp_data", rsp_data, exp_q.pop_front());
        end else check("rsp_valid", 128'(rsp_valid), 128'h0);
    end

    task automatic t_inv_mix();
        go('{OP_INV_MIX, {4{32'hBCA14D8E}}, '1, 8'hFF},
            {4{32'h455313DB}});
        $display("t_inv_mix done");
    endtask

    task automatic t_sub_edges();
        go('{OP_ENC_FINAL, '0, '0, 8'h00}, {16{8'h63}});
        go('{OP_ENC_FINAL, '1, '0, 8'h00}, {16{8'h16}});
        go('{OP_DEC_FINAL, {16{8'h63}}, '0, 8'h00}, '0);
        $display("t_sub_edges done");
    endtask

    task automatic t_key_assist();
        go('{OP_KEY_ASSIST, {32'h0, 32'hDEADBEEF, 32'h63FF0100,
            32'h12345678}, '1, 8'h01}, {32'h63636362, 32'h63636363,
            32'h63FB167D, 32'hFB167C63});
        $display("t_key_assist done");
    endtask

    // every op encoding, back to back, judged by the monitor
    task automatic t_burst();
        logic [127:0] base;
        base = 128'h0F0E0D0C0B0A09080706050403020100;
        for (int k = 0; k < 8; k++)
            i_exec.send('{arp_op_t'(k[2:0]), base ^ {16{k[7:0]}},
                ~base, 8'(k)});
        i_exec.idle();
        repeat (2) @(negedge core_clk);
        check("drained", 128'(exp_q.size()), 128'h0);
        $display("t_burst done");
    endtask

    // reset mid-run clears the output stage at once
    task automatic t_reset();
        go('{OP_ENC_FINAL, '0, '1, 8'h00}, {16{8'h9C}});
        @(posedge core_clk);
        rst_n <= 1'b0;
        mon_on = 1'b0;
        #1;
        check("rst_valid", 128'(rsp_valid), 128'h0);
        check("rst_data", rsp_data, '0);
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        mon_on = 1'b1;
        go('{OP_INV_MIX, '0, '0, 8'h00}, '0);
        $display("t_reset done");
    endtask

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    initial begin
        rst_n = 1'b0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        mon_on = 1'b1;
        t_inv_mix();
        t_sub_edges();
        t_key_assist();
        t_burst();
        t_reset();
        close_out();
    end
endmodule
`default_nettype wire
